// >>> logic/bicfg_in_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "bicfg_params.svh"

module bicfg_in_match (
  input wire logic [31:0] addr, // PCI address.
  input wire bicfg_pkg::bicfg_space_type space, // Cycle space.
  input wire logic mem_en, // Global memory space enable.
  input wire logic io_en, // Global I/O space enable.
  input wire bicfg_pkg::bicfg_in_img_type img, // Image programming.
  output logic hit, // Image claims the cycle.
  output logic [31:0] local_addr // Translated local address.
);

  logic [15:0] mask;
  logic range_hit;

  // Compare only the bits above the block size against the base.
  always_comb begin
    mask = bicfg_pkg::size_mask(img.image_block_size);
    range_hit = ((addr[31:16] ^ img.base_address) & mask) == 16'h0000;
  end

  // A disabled image never claims; space must agree with both global and image selects.
  always_comb begin
    hit = 1'b0;
    if (img.image_enable && range_hit) begin
      if (space == bicfg_pkg::BICFG_SPACE_MEM) begin
        hit = mem_en && (img.address_space_select == `BICFG_ASEL_MEM);
      end else if (space == bicfg_pkg::BICFG_SPACE_IO) begin
        hit = io_en && (img.address_space_select == `BICFG_ASEL_IO);
      end
    end
  end

  // Offset bits below the block size pass through untouched.
  always_comb begin
    local_addr = bicfg_pkg::xlate(addr, img.translation_address, img.image_block_size);
  end

endmodule
`default_nettype wire

// >>> logic/bicfg_out_xlate.sv
`timescale 1ns/1ps
`default_nettype none
`include "bicfg_params.svh"

module bicfg_out_xlate (
  input wire logic [31:0] addr, // Processor address.
  input wire logic write, // High for a processor write.
  input wire bicfg_pkg::bicfg_out_img_type img, // Image programming.
  output logic [31:0] pci_addr, // Address to drive on PCI.
  output logic io_cycle, // High for an I/O space cycle.
  output logic burst_read, // High for a prefetching burst read.
  output logic posted // High for a posted write.
);

  // Translation is skipped entirely when disabled, so the image is a plain window.
  always_comb begin
    pci_addr = img.translation_enable ? bicfg_pkg::xlate(addr, img.translation_address,
                                                         img.image_block_size) : addr;
    io_cycle = (img.address_space_select == `BICFG_ASEL_IO);
    burst_read = !write && img.prefetch_read_enable;
    posted = write && img.posted_write_enable;
  end

endmodule
`default_nettype wire

// >>> logic/bicfg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bicfg_params.svh"

module bicfg_top #(
  parameter int NUM_IMAGES = 2 // Images per direction.
) (
  input wire logic clk_sys, // System clock, 40 MHz.
  input wire logic reset_n, // Asynchronous active-low reset.
  input wire bicfg_pkg::bicfg_global_type glb, // Global enables and window base.
  input wire bicfg_pkg::bicfg_out_img_type out_img0, // Outbound image 0 programming.
  input wire bicfg_pkg::bicfg_out_img_type out_img1, // Outbound image 1 programming.
  input wire bicfg_pkg::bicfg_in_img_type in_img0, // Inbound image 0 programming.
  input wire bicfg_pkg::bicfg_in_img_type in_img1, // Inbound image 1 programming.
  input wire logic proc_valid, // Processor request strobe.
  input wire logic proc_image, // Outbound image addressed.
  input wire logic [31:0] proc_addr, // Processor address.
  input wire logic proc_write, // Processor write.
  output logic pci_valid_ff, // One-cycle PCI cycle request.
  output bicfg_pkg::bicfg_pci_cyc_type pci_cyc_ff, // PCI cycle description.
  output logic proc_refused_ff, // One-cycle refusal, master disabled.
  input wire logic tgt_valid, // PCI target request strobe.
  input wire bicfg_pkg::bicfg_space_type tgt_space, // Space of the PCI cycle.
  input wire logic [31:0] tgt_addr, // PCI address.
  input wire logic tgt_write, // PCI write.
  output logic tgt_done_ff, // One-cycle decode answer.
  output logic tgt_claim_ff, // Cycle claimed.
  output logic tgt_cfg_reg_ff, // Claimed as standard config register.
  output logic tgt_dev_reg_ff, // Claimed as device register.
  output logic [11:0] tgt_reg_offset_ff, // Register offset within window.
  output logic loc_valid_ff, // One-cycle local cycle request.
  output bicfg_pkg::bicfg_loc_cyc_type loc_cyc_ff // Local cycle description.
);

  // The logic below is written for exactly two images in each direction.
  // Any other count is refused at elaboration rather than left to misbehave.
  if (NUM_IMAGES != 2) begin : g_bad_images
    $error("bicfg_top serves exactly two images per direction.");
  end

  logic rst_meta_ff;
  logic rst_sync_ff;

  // Reset enters asynchronously but is released cleanly on the clock.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Outbound path: pick the image, then let the translator shape the PCI cycle.
  bicfg_pkg::bicfg_out_img_type out_sel;
  logic [31:0] out_addr;
  logic out_io;
  logic out_burst;
  logic out_posted;

  always_comb begin
    out_sel = proc_image ? out_img1 : out_img0;
  end

  bicfg_out_xlate u_out_xlate (
    .addr(proc_addr),
    .write(proc_write),
    .img(out_sel),
    .pci_addr(out_addr),
    .io_cycle(out_io),
    .burst_read(out_burst),
    .posted(out_posted)
  );

  bicfg_pkg::bicfg_pci_cyc_type nxt_pci_cyc;
  logic nxt_pci_valid;
  logic nxt_refused;

  // A request with mastering disabled is answered by a refusal, never a PCI cycle.
  always_comb begin
    nxt_pci_valid = proc_valid && glb.bus_master_enable;
    nxt_refused = proc_valid && !glb.bus_master_enable;
    nxt_pci_cyc.address = out_addr;
    nxt_pci_cyc.write = proc_write;
    nxt_pci_cyc.io_cycle = out_io;
    nxt_pci_cyc.burst_read = out_burst;
    nxt_pci_cyc.posted = out_posted;
  end

  // Strobes of the outbound answer.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pci_valid_ff <= `BICFG_RST_OFF;
      proc_refused_ff <= `BICFG_RST_OFF;
    end else begin
      pci_valid_ff <= nxt_pci_valid;
      proc_refused_ff <= nxt_refused;
    end
  end

  // The cycle description is held until the next accepted request.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pci_cyc_ff <= '0;
    end else if (nxt_pci_valid) begin
      pci_cyc_ff <= nxt_pci_cyc;
    end
  end

  // Inbound path: each image decodes on its own.
  logic [1:0] in_hit;
  logic [31:0] in_laddr [2];
  bicfg_pkg::bicfg_in_img_type in_imgs [2];

  always_comb begin
    in_imgs[0] = in_img0;
    in_imgs[1] = in_img1;
  end

  for (genvar g = 0; g < 2; g++) begin : g_in
    bicfg_in_match u_in_match (
      .addr(tgt_addr),
      .space(tgt_space),
      .mem_en(glb.memory_space_enable),
      .io_en(glb.io_space_enable),
      .img(in_imgs[g]),
      .hit(in_hit[g]),
      .local_addr(in_laddr[g])
    );
  end

  logic win_hit;
  logic cfg_hit;

  // The 4K register window answers memory cycles only, and only with memory enabled.
  // Standard config registers need no enable, so they answer straight out of reset.
  always_comb begin
    win_hit = (tgt_space == bicfg_pkg::BICFG_SPACE_MEM) && glb.memory_space_enable
              && (tgt_addr[31:`BICFG_WIN_LSB] == glb.register_window_base_reg);
    cfg_hit = (tgt_space == bicfg_pkg::BICFG_SPACE_CFG)
              && (tgt_addr[7:0] <= `BICFG_CFG_STD_TOP);
  end

  logic img_sel;
  logic img_hit;
  bicfg_pkg::bicfg_in_img_type isel;

  // Image 0 wins if both overlap; software should keep them apart.
  always_comb begin
    img_sel = !in_hit[0];
    img_hit = |in_hit;
    isel = img_sel ? in_img1 : in_img0;
  end

  bicfg_pkg::bicfg_loc_cyc_type nxt_loc_cyc;
  logic nxt_loc_valid;
  logic nxt_claim;
  logic nxt_dev_reg;
  logic nxt_cfg_reg;

  // The register window takes priority over an image that overlaps it.
  always_comb begin
    nxt_dev_reg = tgt_valid && win_hit;
    nxt_cfg_reg = tgt_valid && cfg_hit;
    nxt_loc_valid = tgt_valid && img_hit && !win_hit;
    nxt_claim = nxt_dev_reg || nxt_cfg_reg || nxt_loc_valid;
    nxt_loc_cyc.address = in_laddr[img_sel];
    nxt_loc_cyc.image = img_sel;
    nxt_loc_cyc.write = tgt_write;
    nxt_loc_cyc.posted = tgt_write && isel.posted_write_enable;
    nxt_loc_cyc.prefetch = !tgt_write && isel.prefetch_read_enable;
    nxt_loc_cyc.prefetch_count = isel.prefetch_read_enable ? isel.prefetch_count
                                                           : `BICFG_RST_CNT;
    nxt_loc_cyc.local_burst = tgt_write && isel.burst_write_enable && glb.burst_4_enable;
    nxt_loc_cyc.byte_order = glb.global_byte_order ^ isel.endian_invert;
    nxt_loc_cyc.transfer_code = isel.transfer_code;
    nxt_loc_cyc.destination_port_size = isel.destination_port_size;
  end

  // One-cycle strobes of the inbound answer.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tgt_done_ff <= `BICFG_RST_OFF;
      loc_valid_ff <= `BICFG_RST_OFF;
    end else begin
      tgt_done_ff <= tgt_valid;
      loc_valid_ff <= nxt_loc_valid;
    end
  end

  // Decode result of the latest target request, held until the next one.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tgt_claim_ff <= `BICFG_RST_OFF;
      tgt_cfg_reg_ff <= `BICFG_RST_OFF;
      tgt_dev_reg_ff <= `BICFG_RST_OFF;
      tgt_reg_offset_ff <= '0;
    end else if (tgt_valid) begin
      tgt_claim_ff <= nxt_claim;
      tgt_cfg_reg_ff <= nxt_cfg_reg;
      tgt_dev_reg_ff <= nxt_dev_reg;
      tgt_reg_offset_ff <= tgt_addr[`BICFG_WIN_LSB-1:0];
    end
  end

  // Local cycle description is only updated by a cycle that an image takes.
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      loc_cyc_ff <= '0;
    end else if (nxt_loc_valid) begin
      loc_cyc_ff <= nxt_loc_cyc;
    end
  end

endmodule
`default_nettype wire

// >>> pkg/bicfg_params.svh
// Function
// - Outbound image posted-write enable makes processor writes posted.
// - Outbound image address-space select picks PCI memory or I/O cycles.
// - Outbound prefetch-read enable turns processor reads into PCI burst reads.
// - Outbound translation applies only while the image translation enable is 1.
// - Outbound block size sets image size and count of replaced upper lines.
// - Outbound translation address bits 31..16 replace upper PCI address bits.
// - No PCI master transaction starts before bus master enable is set.
// - Standard config registers by config or memory; device registers memory only. Here standard config registers answer config cycles only.
// - Standard config registers answer right after reset without programming.
// - Memory cycles claimed only with memory enable and image selecting memory.
// - Programmable base places a 4K register window in PCI memory space.
// - I/O cycles claimed only with I/O enable and image selecting I/O.
// - Two inbound images; each decodes only while its enable is set.
// - Inbound posted-write enable makes PCI writes posted, finished locally later.
// - Inbound prefetch enable serves burst reads prefetched by prefetch count.
// - Per-image burst-write enable with global four-beat enable allows local bursts.
// - Inbound endian invert flips the global byte order for that image.
// - Inbound block size sets image size and replaced upper address lines.
// - Inbound address-space select chooses memory or I/O cycles to answer.
// - Per-image transfer code is driven during local cycles of that image.
// - Per-image destination port size sizes the local-bus cycles.
// - Inbound base bits 31..16 set monitored range; translation gives local upper bits.
`ifndef BICFG_PARAMS_SVH
`define BICFG_PARAMS_SVH

`define BICFG_ASEL_MEM 1'b0
`define BICFG_ASEL_IO 1'b1
`define BICFG_WIN_LSB 12
`define BICFG_IMG_LSB 16
`define BICFG_CFG_STD_TOP 8'h3f
`define BICFG_RST_OFF 1'b0
`define BICFG_RST_ADDR 32'h0000_0000
`define BICFG_RST_CNT 6'h00

`endif

// >>> pkg/bicfg_pkg.sv
`default_nettype none
package bicfg_pkg;

  // Kind of cycle that a PCI initiator presents to the target side.
  typedef enum logic [1:0] {
    BICFG_SPACE_MEM = 2'h0,
    BICFG_SPACE_IO = 2'h1,
    BICFG_SPACE_CFG = 2'h2
  } bicfg_space_type;

  // Programming of one outbound (processor to PCI) image.
  typedef struct packed {
    logic posted_write_enable;
    logic address_space_select;
    logic prefetch_read_enable;
    logic translation_enable;
    logic [3:0] image_block_size;
    logic [15:0] translation_address;
  } bicfg_out_img_type;

  // Programming of one inbound (PCI to local) image.
  typedef struct packed {
    logic image_enable;
    logic posted_write_enable;
    logic prefetch_read_enable;
    logic burst_write_enable;
    logic endian_invert;
    logic address_space_select;
    logic [3:0] image_block_size;
    logic [3:0] transfer_code;
    logic [1:0] destination_port_size;
    logic [15:0] base_address;
    logic [15:0] translation_address;
    logic [5:0] prefetch_count;
  } bicfg_in_img_type;

  // Global enables shared by both directions.
  typedef struct packed {
    logic bus_master_enable;
    logic memory_space_enable;
    logic io_space_enable;
    logic global_byte_order;
    logic burst_4_enable;
    logic [19:0] register_window_base_reg;
  } bicfg_global_type;

  // Cycle description handed to the PCI master engine.
  typedef struct packed {
    logic [31:0] address;
    logic write;
    logic io_cycle;
    logic burst_read;
    logic posted;
  } bicfg_pci_cyc_type;

  // Cycle description handed to the local-bus master engine.
  typedef struct packed {
    logic [31:0] address;
    logic image;
    logic write;
    logic posted;
    logic prefetch;
    logic [5:0] prefetch_count;
    logic local_burst;
    logic byte_order;
    logic [3:0] transfer_code;
    logic [1:0] destination_port_size;
  } bicfg_loc_cyc_type;

  // Upper-half mask of an image: set bits are compared and replaced.
  function automatic logic [15:0] size_mask(input logic [3:0] bs);
    size_mask = 16'hffff << bs;
  endfunction

  // Replaces the masked upper bits, keeping the offset inside the image.
  function automatic logic [31:0] xlate(input logic [31:0] a, input logic [15:0] ta, input logic [3:0] bs);
    logic [15:0] m;
    m = size_mask(bs);
    xlate = {(a[31:16] & ~m) | (ta & m), a[15:0]};
  endfunction

endpackage
`default_nettype wire

// >>> verif/bicfg_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the PCI target and the local memory; both accept every cycle offered.
module bicfg_far_model (
  input wire logic clk_sys, // System clock.
  input wire logic pci_valid, // PCI cycle start pulse.
  input wire logic loc_valid, // Local cycle start pulse.
  output int pci_seen, // PCI cycles accepted.
  output int loc_seen // Local cycles accepted.
);
  int pci_cnt = 0;
  int loc_cnt = 0;
  // Each count has one driver; the ports only show it.
  assign pci_seen = pci_cnt;
  assign loc_seen = loc_cnt;
  // No wait states are modelled, so the counts show every pulse the bridge raised.
  always @(posedge clk_sys) begin
    if (pci_valid === 1'b1) pci_cnt <= pci_cnt + 1;
    if (loc_valid === 1'b1) loc_cnt <= loc_cnt + 1;
  end
endmodule

`default_nettype wire

// >>> verif/bicfg_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module bicfg_top_sva #(
  parameter int NUM_IMAGES = 2 // Images per direction.
) (
  input wire logic clk_sys, // Clock.
  input wire logic reset_n, // Reset.
  input wire bicfg_pkg::bicfg_global_type glb, // Globals.
  input wire bicfg_pkg::bicfg_out_img_type out_img0, // Outbound 0.
  input wire bicfg_pkg::bicfg_out_img_type out_img1, // Outbound 1.
  input wire bicfg_pkg::bicfg_in_img_type in_img0, // Inbound 0.
  input wire bicfg_pkg::bicfg_in_img_type in_img1, // Inbound 1.
  input wire logic proc_valid, // Request.
  input wire logic proc_image, // Image.
  input wire logic [31:0] proc_addr, // Address.
  input wire logic proc_write, // Write.
  input wire logic pci_valid_ff, // PCI start.
  input wire bicfg_pkg::bicfg_pci_cyc_type pci_cyc_ff, // PCI cycle.
  input wire logic proc_refused_ff, // Refusal.
  input wire logic tgt_valid, // Target request.
  input wire bicfg_pkg::bicfg_space_type tgt_space, // Space.
  input wire logic [31:0] tgt_addr, // Address.
  input wire logic tgt_write, // Write.
  input wire logic tgt_done_ff, // Answer.
  input wire logic tgt_claim_ff, // Claim.
  input wire logic tgt_cfg_reg_ff, // Config hit.
  input wire logic tgt_dev_reg_ff, // Window hit.
  input wire logic [11:0] tgt_reg_offset_ff, // Offset.
  input wire logic loc_valid_ff, // Local start.
  input wire bicfg_pkg::bicfg_loc_cyc_type loc_cyc_ff // Local cycle.
);
  bicfg_pkg::bicfg_out_img_type sel;
  logic [15:0] msk;
  logic [31:0] xaddr;
  logic take;
  // Expected outbound address, rebuilt here rather than borrowed from the design.
  assign sel = proc_image ? out_img1 : out_img0;
  assign msk = 16'hffff << sel.image_block_size;
  assign xaddr = sel.translation_enable ? {(proc_addr[31:16] & ~msk) | (sel.translation_address & msk),
    proc_addr[15:0]} : proc_addr;
  assign take = proc_valid && glb.bus_master_enable;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_master_gate: assert property (pci_valid_ff |-> $past(take))
    else $error("PCI cycle started without master enable");
  a_refuse_pulse: assert property (proc_valid && !glb.bus_master_enable
    |=> proc_refused_ff && !pci_valid_ff)
    else $error("request not refused");
  a_cycle_kind: assert property (take |=> pci_valid_ff
    && pci_cyc_ff.io_cycle == $past(sel.address_space_select)
    && pci_cyc_ff.posted == $past(proc_write & sel.posted_write_enable)
    && pci_cyc_ff.burst_read == $past(!proc_write & sel.prefetch_read_enable))
    else $error("PCI cycle kind wrong");
  a_xlate_addr: assert property (take |=> pci_cyc_ff.address == $past(xaddr))
    else $error("PCI address wrong");
  a_done_each: assert property (tgt_valid |=> tgt_done_ff
    && tgt_reg_offset_ff == $past(tgt_addr[11:0]))
    else $error("target answer missing");
  a_cfg_claim: assert property (tgt_valid && tgt_space == bicfg_pkg::BICFG_SPACE_CFG
    && tgt_addr[7:0] <= 8'h3f |=> tgt_claim_ff && tgt_cfg_reg_ff && !loc_valid_ff)
    else $error("config access not claimed");
  a_mem_gate: assert property (tgt_valid && tgt_space == bicfg_pkg::BICFG_SPACE_MEM
    && !glb.memory_space_enable |=> !tgt_claim_ff && !loc_valid_ff)
    else $error("memory claimed while disabled");
  a_io_gate: assert property (tgt_valid && tgt_space == bicfg_pkg::BICFG_SPACE_IO
    && !glb.io_space_enable |=> !tgt_claim_ff && !loc_valid_ff)
    else $error("I/O claimed while disabled");
  a_window_space: assert property (tgt_done_ff && tgt_dev_reg_ff
    |-> $past(tgt_space) == bicfg_pkg::BICFG_SPACE_MEM && $past(glb.memory_space_enable)
    && $past(tgt_addr[31:12]) == $past(glb.register_window_base_reg) && !loc_valid_ff)
    else $error("window claim wrong");
  a_img_enable: assert property (loc_valid_ff |-> tgt_claim_ff
    && (loc_cyc_ff.image ? $past(in_img1.image_enable) : $past(in_img0.image_enable)))
    else $error("local cycle without claim");

  c_refused: cover property (proc_refused_ff);
  c_local_write: cover property (loc_valid_ff && loc_cyc_ff.write);
  c_window: cover property (tgt_done_ff && tgt_dev_reg_ff);
endmodule

bind bicfg_top bicfg_top_sva #(.NUM_IMAGES(NUM_IMAGES)) u_sva (.clk_sys(clk_sys), .reset_n(reset_n), .glb(glb),
  .out_img0(out_img0), .out_img1(out_img1), .in_img0(in_img0), .in_img1(in_img1), .proc_valid(proc_valid),
  .proc_image(proc_image), .proc_addr(proc_addr), .proc_write(proc_write), .pci_valid_ff(pci_valid_ff),
  .pci_cyc_ff(pci_cyc_ff), .proc_refused_ff(proc_refused_ff), .tgt_valid(tgt_valid), .tgt_space(tgt_space),
  .tgt_addr(tgt_addr), .tgt_write(tgt_write), .tgt_done_ff(tgt_done_ff), .tgt_claim_ff(tgt_claim_ff),
  .tgt_cfg_reg_ff(tgt_cfg_reg_ff), .tgt_dev_reg_ff(tgt_dev_reg_ff), .tgt_reg_offset_ff(tgt_reg_offset_ff),
  .loc_valid_ff(loc_valid_ff), .loc_cyc_ff(loc_cyc_ff));

`default_nettype wire

// >>> verif/bicfg_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module bicfg_top_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  bicfg_pkg::bicfg_global_type glb = '0;
  bicfg_pkg::bicfg_out_img_type oi0 = '0, oi1 = '0;
  bicfg_pkg::bicfg_in_img_type ii0 = '0, ii1 = '0;
  logic proc_valid = 1'b0, proc_image = 1'b0, proc_write = 1'b0, tgt_valid = 1'b0, tgt_write = 1'b0;
  logic [31:0] proc_addr = '0, tgt_addr = '0, r, a;
  bicfg_pkg::bicfg_space_type tgt_space = bicfg_pkg::BICFG_SPACE_MEM;
  logic pci_valid_ff, proc_refused_ff, tgt_done_ff, tgt_claim_ff, tgt_cfg_reg_ff, tgt_dev_reg_ff, loc_valid_ff;
  logic [11:0] tgt_reg_offset_ff;
  bicfg_pkg::bicfg_pci_cyc_type pci_cyc_ff;
  bicfg_pkg::bicfg_loc_cyc_type loc_cyc_ff;
  int miscompares = 0, check_count = 0, pci_seen, loc_seen, pci_exp = 0, loc_exp = 0;

  bicfg_top #(.NUM_IMAGES(2)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .glb(glb), .out_img0(oi0), .out_img1(oi1),
    .in_img0(ii0), .in_img1(ii1), .proc_valid(proc_valid), .proc_image(proc_image), .proc_addr(proc_addr),
    .proc_write(proc_write), .pci_valid_ff(pci_valid_ff), .pci_cyc_ff(pci_cyc_ff), .proc_refused_ff(proc_refused_ff),
    .tgt_valid(tgt_valid), .tgt_space(tgt_space), .tgt_addr(tgt_addr), .tgt_write(tgt_write),
    .tgt_done_ff(tgt_done_ff), .tgt_claim_ff(tgt_claim_ff), .tgt_cfg_reg_ff(tgt_cfg_reg_ff),
    .tgt_dev_reg_ff(tgt_dev_reg_ff), .tgt_reg_offset_ff(tgt_reg_offset_ff), .loc_valid_ff(loc_valid_ff),
    .loc_cyc_ff(loc_cyc_ff));
  bicfg_far_model far (.clk_sys(clk_sys), .pci_valid(pci_valid_ff), .loc_valid(loc_valid_ff), .pci_seen(pci_seen),
    .loc_seen(loc_seen));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move a fixed 2 ns after the edge so the design never races the bench.
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xl(input logic [31:0] ad, input logic [15:0] ta, input logic [3:0] bs);
    logic [15:0] m;
    m = 16'hffff << bs;
    return {(ad[31:16] & ~m) | (ta & m), ad[15:0]};
  endfunction

  function automatic logic hit(input bicfg_pkg::bicfg_in_img_type n, input bicfg_pkg::bicfg_space_type sp,
    input logic [31:0] ad);
    logic [15:0] m;
    m = 16'hffff << n.image_block_size;
    return n.image_enable && ((ad[31:16] ^ n.base_address) & m) == 16'h0000 &&
      (sp == bicfg_pkg::BICFG_SPACE_MEM ? !n.address_space_select && glb.memory_space_enable :
      sp == bicfg_pkg::BICFG_SPACE_IO && n.address_space_select && glb.io_space_enable);
  endfunction

  // Request is held high across calls, so consecutive calls run back to back.
  task automatic proc_req(input logic img, input logic wr, input logic [31:0] ad);
    bicfg_pkg::bicfg_out_img_type o;
    bicfg_pkg::bicfg_pci_cyc_type e;
    o = img ? oi1 : oi0;
    e = {o.translation_enable ? xl(ad, o.translation_address, o.image_block_size) : ad, wr,
      o.address_space_select, !wr & o.prefetch_read_enable, wr & o.posted_write_enable};
    if (!glb.bus_master_enable) e = pci_cyc_ff;
    proc_valid = 1'b1;
    proc_image = img;
    proc_write = wr;
    proc_addr = ad;
    step();
    pci_exp += glb.bus_master_enable;
    chk("pci_valid", pci_valid_ff, glb.bus_master_enable);
    chk("refused", proc_refused_ff, !glb.bus_master_enable);
    chk("pci_cyc", pci_cyc_ff, e);
  endtask

  task automatic tgt_req(input bicfg_pkg::bicfg_space_type sp, input logic wr, input logic [31:0] ad);
    bicfg_pkg::bicfg_in_img_type n;
    bicfg_pkg::bicfg_loc_cyc_type e;
    logic cfg, dev, h0, h1;
    cfg = sp == bicfg_pkg::BICFG_SPACE_CFG && ad[7:0] <= 8'h3f;
    dev = sp == bicfg_pkg::BICFG_SPACE_MEM && glb.memory_space_enable && ad[31:12] == glb.register_window_base_reg;
    h0 = hit(ii0, sp, ad) && !dev;
    h1 = hit(ii1, sp, ad) && !dev && !h0;
    n = h1 ? ii1 : ii0;
    e = {xl(ad, n.translation_address, n.image_block_size), h1, wr, wr & n.posted_write_enable,
      !wr & n.prefetch_read_enable, n.prefetch_read_enable ? n.prefetch_count : 6'h00,
      wr & n.burst_write_enable & glb.burst_4_enable, glb.global_byte_order ^ n.endian_invert,
      n.transfer_code, n.destination_port_size};
    if (!(h0 || h1)) e = loc_cyc_ff;
    tgt_valid = 1'b1;
    tgt_space = sp;
    tgt_write = wr;
    tgt_addr = ad;
    step();
    loc_exp += h0 || h1;
    chk("claim", {tgt_done_ff, tgt_claim_ff}, {1'b1, cfg | dev | h0 | h1});
    chk("reg kind", {tgt_cfg_reg_ff, tgt_dev_reg_ff}, {cfg, dev});
    chk("offset", tgt_reg_offset_ff, ad[11:0]);
    chk("loc_valid", loc_valid_ff, h0 | h1);
    chk("loc_addr", {loc_cyc_ff.address, loc_cyc_ff.image}, {e.address, e.image});
    chk("loc_cyc", loc_cyc_ff, e);
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #100us;
    miscompares++;
    summarize();
  end

  initial begin
    void'($urandom(32'h6bf8));
    repeat (3) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    repeat (3) step();
    chk("quiet", {pci_valid_ff, tgt_claim_ff, loc_valid_ff}, 3'b000);
    tgt_req(bicfg_pkg::BICFG_SPACE_CFG, 1'b0, 32'h0000_0004);
    tgt_req(bicfg_pkg::BICFG_SPACE_CFG, 1'b0, 32'h0000_0040);
    tgt_valid = 1'b0;
    $display("test reset done");
    proc_req(1'b0, 1'b1, 32'h1234_5678);
    proc_valid = 1'b0;
    step();
    glb.bus_master_enable = 1'b1;
    // Random outbound traffic, block size ends forced on the first two requests.
    for (int i = 0; i < 60; i++) begin
      r = $urandom;
      oi0 = 24'($urandom);
      oi1 = 24'($urandom);
      if (i < 2) oi0.image_block_size = i ? 4'hf : 4'h0;
      if (i < 2) oi0.translation_enable = 1'b1;
      proc_req(r[0] & (i > 1), r[1], $urandom);
    end
    proc_valid = 1'b0;
    $display("test outbound done");
    // Random inbound traffic, addresses steered onto images and the window most of the time.
    for (int i = 0; i < 150; i++) begin
      r = $urandom;
      a = $urandom;
      ii0 = 54'({$urandom, $urandom});
      ii1 = 54'({$urandom, $urandom});
      glb = 25'($urandom);
      if (r[1:0] == 2'h0) a[31:16] = ii0.base_address;
      if (r[1:0] == 2'h1) a[31:16] = ii1.base_address;
      if (r[1:0] == 2'h2) a[31:12] = glb.register_window_base_reg;
      tgt_req(bicfg_pkg::bicfg_space_type'(r[3:2] == 2'h3 ? 2'h0 : r[3:2]), r[4], a);
    end
    tgt_valid = 1'b0;
    step();
    chk("pci count", pci_seen, pci_exp);
    chk("local count", loc_seen, loc_exp);
    $display("test inbound done");
    summarize();
  end
endmodule

`default_nettype wire
